/* File: common/gip_regs.svh */
// constants of the gauge i2c target port
`ifndef GIP_REGS_SVH
`define GIP_REGS_SVH
`define GIP_ADDR_LO 7'h36
`define GIP_ADDR_HI 7'h37
`define GIP_PTR_TOP 8'hFF
`define GIP_BYTE_LAST 3'h7
`define GIP_FILT_RESET 1'b1
`define GIP_CLK_MHZ 100
`define GIP_FILT_SLOW_NS 50
`define GIP_FILT_FAST_NS 10
`define GIP_FILT_SLOW_CYC ((`GIP_FILT_SLOW_NS * `GIP_CLK_MHZ + 999) / 1000)
`define GIP_FILT_FAST_CYC ((`GIP_FILT_FAST_NS * `GIP_CLK_MHZ + 999) / 1000)
`endif

/* File: common/gip_pkg.sv */
// types of the gauge i2c target port
package gip_pkg;
	typedef enum logic [2:0] {
		GIP_S_IDLE = 3'b000,
		GIP_S_ADDR = 3'b001,
		GIP_S_PTR = 3'b010,
		GIP_S_WR = 3'b011,
		GIP_S_RD = 3'b100,
		GIP_S_ACK = 3'b101,
		GIP_S_MACK = 3'b110,
		GIP_S_IGN = 3'b111
	} gip_state_t;
	typedef logic [7:0] gip_ptr_t;
	typedef logic [8:0] gip_waddr_t;
	typedef logic [15:0] gip_word_t;
endpackage : gip_pkg

/* File: logic/gip_filt.sv */
// two-flop synchroniser and glitch filter for one bus line
`timescale 1ns/1ps
`include "gip_regs.svh"
module gip_filt #(
	parameter int unsigned SLOW_CYC = 5,
	parameter int unsigned FAST_CYC = 1
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic raw,
	input wire logic fast,
	output logic level_q
);
	logic s1_q;
	logic s2_q;
	logic [7:0] cnt_q;
	wire [7:0] limit = fast ? FAST_CYC[7:0] : SLOW_CYC[7:0];
	wire [7:0] cnt_inc = 8'(cnt_q + 8'h01);
	wire settle = cnt_inc >= limit;

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			s1_q <= `GIP_FILT_RESET;
			s2_q <= `GIP_FILT_RESET;
		end
		else
		begin
			s1_q <= raw;
			s2_q <= s1_q;
		end
	end

	// a new level must hold for the whole window before it passes
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			level_q <= `GIP_FILT_RESET;
			cnt_q <= 8'h00;
		end
		else if (s2_q == level_q)
			cnt_q <= 8'h00;
		else if (settle)
		begin
			level_q <= s2_q;
			cnt_q <= 8'h00;
		end
		else
			cnt_q <= cnt_inc;
	end
endmodule : gip_filt

/* File: logic/gip_target.sv */
// i2c target port reaching the gauge word space
// Operation
// RL1 - receiver acks by holding sda low across the ninth clock high
// RL2 - receiver nacks by leaving sda released across the ninth clock
// RL3 - controller retries later after a missing acknowledge
// RL4 - every pointer value is acknowledged, even with no register behind it
// RL5 - after start and matching address, ack in the clock after r/w
// RL6 - low address maps 00-FF to 000-0FF, high address 80-FF to 180-1FF
// RL7 - port never stretches the clock
// RL8 - general call address is never acknowledged
// RL9 - no device id response
// RL10 - works at any scl rate from 20 to 400 khz
// RL11 - controller should keep scl above 20 khz
// RL12 - single write: address, pointer, data; data commits on next sda rise
// RL13 - sequential write: every data byte acked and committed
// RL14 - stop returns input filters to slow setting, repeated start keeps them
// RL15 - word write: pointer byte, then low byte, then high byte
// RL16 - pointer increments after the last bit of each received word
// RL17 - auto-incremented data beyond the top word is discarded
// RL18 - writes to read-only words are dropped, reserved ones are not
// RL19 - single read: pointer, repeated start, read address, one byte, nack
// RL20 - sequential read: controller acks for more, returns successive words
// RL21 - stop leaves the pointer untouched
// RL22 - scl is only sampled, never driven
`timescale 1ns/1ps
`include "gip_regs.svh"
module gip_target (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic filt_fast_set,
	output logic filt_fast,
	output gip_pkg::gip_waddr_t rd_addr,
	input wire gip_pkg::gip_word_t rd_data,
	output logic wr_en,
	output gip_pkg::gip_waddr_t wr_addr,
	output gip_pkg::gip_word_t wr_data,
	input wire logic wr_ro
);
	import gip_pkg::*;
	gip_state_t state_q, nxt_q;
	logic scl_f, sda_f;
	logic scl_p_q, sda_p_q;
	logic fast_q, oe_q, hi_q, mseen_q, page_q, ovf_q, pend_q;
	logic [7:0] sh_q, tx_q;
	logic [2:0] cnt_q;
	gip_ptr_t ptr_q, lo_q;
	gip_waddr_t wa_q;
	gip_word_t wd_q;

	// clock is only sampled, no output exists for it [RL7] [RL22]
	gip_filt #(
		.SLOW_CYC(`GIP_FILT_SLOW_CYC),
		.FAST_CYC(`GIP_FILT_FAST_CYC)
	) u_scl (
		.core_clk(core_clk),
		.rst(rst),
		.raw(scl_in),
		.fast(fast_q),
		.level_q(scl_f)
	);
	gip_filt #(
		.SLOW_CYC(`GIP_FILT_SLOW_CYC),
		.FAST_CYC(`GIP_FILT_FAST_CYC)
	) u_sda (
		.core_clk(core_clk),
		.rst(rst),
		.raw(sda_in),
		.fast(fast_q),
		.level_q(sda_f)
	);

	// bus events, oversampled; 100 mhz leaves wide margin at 400 khz [RL10]
	wire scl_rise = scl_f & ~scl_p_q;
	wire scl_fall = ~scl_f & scl_p_q;
	wire sda_rise = sda_f & ~sda_p_q;
	wire start_w = ~sda_f & sda_p_q & scl_f & scl_p_q;
	wire stop_w = sda_rise & scl_f & scl_p_q;
	wire [7:0] rx_byte = {sh_q[6:0], sda_f};
	wire byte_end = scl_rise & (cnt_q == `GIP_BYTE_LAST);
	// only the two own addresses match: general call and id never ack [RL8] [RL9]
	wire addr_hit = (rx_byte[7:1] == `GIP_ADDR_LO) | (rx_byte[7:1] == `GIP_ADDR_HI);
	// upper page only reaches pointers with the top bit set [RL6]
	wire acc_ok = ~ovf_q & (~page_q | ptr_q[7]);
	wire [7:0] tx_sel = acc_ok ? (hi_q ? rd_data[15:8] : rd_data[7:0]) : 8'h00;
	wire word_done = (state_q == GIP_S_WR) & byte_end & hi_q;
	wire rd_done = (state_q == GIP_S_RD) & byte_end & hi_q;
	// held word goes out on the next sda rise or when the next word lands [RL12]
	wire commit = pend_q & (sda_rise | word_done);
	assign sda_out = 1'b0;
	assign sda_oe = oe_q;
	assign filt_fast = fast_q;
	assign rd_addr = {page_q, ptr_q};
	assign wr_addr = wa_q;
	assign wr_data = wd_q;
	assign wr_en = commit & ~wr_ro; // [RL18]
	// previous levels reset to the idle high, so reset makes no false edge
	always_ff @(posedge core_clk)
	begin
		scl_p_q <= rst | scl_f;
		sda_p_q <= rst | sda_f;
	end

	// stop drops back to slow filtering; repeated start leaves it alone
	always_ff @(posedge core_clk)
	begin
		if (rst | stop_w)
			fast_q <= 1'b0; // [RL14]
		else if (filt_fast_set)
			fast_q <= 1'b1;
	end

	// pointer survives stop; only a pointer phase or an advance moves it
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			ptr_q <= 8'h00;
			ovf_q <= 1'b0;
		end
		else if ((state_q == GIP_S_PTR) & byte_end & ~start_w & ~stop_w)
		begin
			ptr_q <= rx_byte; // [RL15] [RL21]
			ovf_q <= 1'b0;
		end
		else if ((word_done | rd_done) & ~start_w & ~stop_w)
		begin
			if (ptr_q == `GIP_PTR_TOP)
				ovf_q <= 1'b1; // [RL17]
			else
				ptr_q <= 8'(ptr_q + 8'h01); // [RL16] [RL20]
		end
	end

	// completed word waits for its commit edge; out-of-range data never pends
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			pend_q <= 1'b0;
			wa_q <= 9'h000;
			wd_q <= 16'h0000;
		end
		else if (word_done & ~start_w & ~stop_w)
		begin
			pend_q <= acc_ok; // [RL17] [RL13]
			wa_q <= {page_q, ptr_q};
			wd_q <= {rx_byte, lo_q}; // [RL15]
		end
		else if (commit)
			pend_q <= 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			state_q <= GIP_S_IDLE;
			nxt_q <= GIP_S_IDLE;
			sh_q <= 8'h00;
			tx_q <= 8'h00;
			cnt_q <= 3'h0;
			oe_q <= 1'b0;
			hi_q <= 1'b0;
			mseen_q <= 1'b0;
			page_q <= 1'b0;
			lo_q <= 8'h00;
		end
		else if (start_w)
		begin
			state_q <= GIP_S_ADDR; // [RL5]
			cnt_q <= 3'h0;
			oe_q <= 1'b0;
			hi_q <= 1'b0;
		end
		else if (stop_w)
		begin
			state_q <= GIP_S_IDLE;
			oe_q <= 1'b0;
		end
		else
		begin
			case (state_q)
				GIP_S_ADDR, GIP_S_PTR, GIP_S_WR:
				begin
					if (scl_rise)
					begin
						sh_q <= rx_byte;
						cnt_q <= 3'(cnt_q + 3'h1);
					end
					if (byte_end)
					begin
						state_q <= GIP_S_ACK;
						nxt_q <= GIP_S_WR;
						if (state_q == GIP_S_ADDR)
						begin
							if (addr_hit)
							begin
								page_q <= rx_byte[1]; // [RL6]
								nxt_q <= rx_byte[0] ? GIP_S_RD : GIP_S_PTR; // [RL19]
							end
							else
								state_q <= GIP_S_IGN; // [RL2] [RL8]
						end
						else if (state_q == GIP_S_PTR)
							hi_q <= 1'b0; // [RL4]
						else
						begin
							lo_q <= rx_byte;
							hi_q <= ~hi_q;
						end
					end
				end
				GIP_S_ACK:
				begin
					// pull low after the eighth fall, release after the ninth [RL1]
					if (scl_fall)
					begin
						if (!oe_q)
							oe_q <= 1'b1; // [RL1] [RL5]
						else
						begin
							state_q <= nxt_q;
							cnt_q <= 3'h0;
							oe_q <= 1'b0;
							if (nxt_q == GIP_S_RD)
							begin
								tx_q <= tx_sel;
								oe_q <= ~tx_sel[7];
							end
						end
					end
				end
				GIP_S_RD:
				begin
					if (scl_fall && cnt_q != 3'h0)
					begin
						tx_q <= {tx_q[6:0], 1'b0};
						oe_q <= ~tx_q[6];
					end
					if (scl_rise)
						cnt_q <= 3'(cnt_q + 3'h1);
					if (byte_end)
					begin
						state_q <= GIP_S_MACK;
						mseen_q <= 1'b0;
						hi_q <= ~hi_q; // [RL20]
					end
				end
				GIP_S_MACK:
				begin
					if (scl_fall)
					begin
						if (!mseen_q)
							oe_q <= 1'b0;
						else
						begin
							state_q <= GIP_S_RD; // [RL20]
							cnt_q <= 3'h0;
							tx_q <= tx_sel;
							oe_q <= ~tx_sel[7];
						end
					end
					if (scl_rise)
					begin
						mseen_q <= 1'b1;
						if (sda_f)
							state_q <= GIP_S_IGN; // [RL19] [RL20]
					end
				end
				GIP_S_IDLE, GIP_S_IGN:
					oe_q <= 1'b0;
				default:
					state_q <= GIP_S_IDLE;
			endcase
		end
	end

	// a refused byte leaves sda released; the controller retries later [RL3]
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_word_end;
		(state_q == GIP_S_WR) && byte_end && hi_q && !start_w && !stop_w;
	endsequence
	sequence s_addr_ok;
		(state_q == GIP_S_ADDR) && byte_end && addr_hit && !start_w && !stop_w;
	endsequence
	property p_ack_hold;
		(state_q == GIP_S_ACK) && oe_q && scl_f && !start_w && !stop_w |=> oe_q;
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("ack released while scl high"); // [RL1]
	property p_addr_nack;
		(state_q == GIP_S_ADDR) && byte_end && !addr_hit && !start_w && !stop_w
			|=> (state_q == GIP_S_IGN) && !sda_oe;
	endproperty
	a_addr_nack: assert property (p_addr_nack) else $error("foreign address acked"); // [RL8]
	property p_addr_ack;
		s_addr_ok |=> (state_q == GIP_S_ACK) && !sda_oe;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("own address not acked"); // [RL5]
	property p_ptr_ack;
		(state_q == GIP_S_PTR) && byte_end && !start_w && !stop_w
			|=> (state_q == GIP_S_ACK) && (nxt_q == GIP_S_WR) && (ptr_q == $past(rx_byte));
	endproperty
	a_ptr_ack: assert property (p_ptr_ack) else $error("pointer not acked"); // [RL4]
	property p_stop_slow;
		stop_w |=> !filt_fast;
	endproperty
	a_stop_slow: assert property (p_stop_slow) else $error("filters fast after stop"); // [RL14]
	property p_ptr_keep;
		stop_w |=> $stable(ptr_q) && $stable(page_q) && (state_q == GIP_S_IDLE);
	endproperty
	a_ptr_keep: assert property (p_ptr_keep) else $error("pointer moved on stop"); // [RL21]
	// upper page below 80 still advances, but its word must not pend
	property p_inc;
		s_word_end ##0 (!ovf_q && ptr_q != `GIP_PTR_TOP)
			|=> (ptr_q == 8'($past(ptr_q) + 8'h01))
			&& (pend_q == (!$past(page_q) || ($past(ptr_q) >= 8'h80)));
	endproperty
	a_inc: assert property (p_inc) else $error("pointer not advanced"); // [RL16]
	property p_ovf_drop;
		s_word_end ##0 ovf_q |=> !pend_q ##1 !wr_en;
	endproperty
	a_ovf_drop: assert property (p_ovf_drop) else $error("overflow data kept"); // [RL17]
	property p_ro_drop;
		pend_q && sda_rise && !word_done |-> (wr_en == !wr_ro) ##1 !pend_q;
	endproperty
	a_ro_drop: assert property (p_ro_drop) else $error("held word commit wrong"); // [RL18]
	property p_commit;
		wr_en |-> pend_q && (sda_rise || word_done) ##1 (!pend_q || $past(word_done));
	endproperty
	a_commit: assert property (p_commit) else $error("commit off its edge"); // [RL12]
	property p_wr_ack;
		(state_q == GIP_S_WR) && byte_end && !start_w && !stop_w |=> state_q == GIP_S_ACK;
	endproperty
	a_wr_ack: assert property (p_wr_ack) else $error("data byte not acked"); // [RL13]
endmodule : gip_target

/* File: tb/gip_ctrl_model.sv */
// bus controller model for the target port
`timescale 1ns/1ps
module gip_ctrl_model #(
	parameter int QTR = 63 // quarter bit, ~397 khz, above 20 khz
) (
	input wire logic core_clk,
	input wire logic sda_in,
	output logic scl,
	output logic sda
);
	initial
	begin
		scl = 1'b1;
		sda = 1'b1;
	end
	task automatic hold();
		repeat (QTR) @(posedge core_clk);
		#1;
	endtask : hold
	// sda moves only while scl is low, so no false start or stop
	task automatic clk_bit(input logic b, output logic r);
		sda = b;
		hold();
		scl = 1'b1;
		hold();
		r = sda_in;
		hold();
		scl = 1'b0;
		hold();
	endtask : clk_bit
	// also serves as repeated start from scl low
	task automatic start();
		sda = 1'b1;
		hold();
		scl = 1'b1;
		hold();
		sda = 1'b0;
		hold();
		scl = 1'b0;
		hold();
	endtask : start
	task automatic stop();
		sda = 1'b0;
		hold();
		scl = 1'b1;
		hold();
		sda = 1'b1;
		hold();
	endtask : stop
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			clk_bit(b[i], r);
		clk_bit(1'b1, r); // released in the ack slot
		ack = !r;
	endtask : wbyte
	task automatic rbyte(input logic more, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			clk_bit(1'b1, r);
			b[i] = r;
		end
		clk_bit(!more, r); // ack for more, nack on last
	endtask : rbyte
endmodule : gip_ctrl_model

/* File: tb/gip_target_tb_top.sv */
// testbench for the gauge i2c target port
`timescale 1ns/1ps
module gip_target_tb_top;
	import gip_pkg::*;
	logic core_clk;
	logic rst;
	logic filt_fast_set;
	logic sda_oe;
	logic sda_out;
	logic filt_fast;
	logic wr_en;
	logic wr_ro;
	logic scl;
	logic sda_m;
	logic sda_w;
	gip_waddr_t rd_addr;
	gip_waddr_t wr_addr;
	gip_word_t rd_data;
	gip_word_t wr_data;
	gip_word_t w;
	logic [7:0] b;
	int failures = 0;
	int total_checks = 0;
	logic [24:0] wlog [$];
	// pull-up wire: high unless someone pulls low
	assign sda_w = sda_m & !(sda_oe & !sda_out);
	assign rd_data = {7'h55, rd_addr};
	assign wr_ro = (wr_addr == 9'h0FE);
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// scl comes from the controller only
	gip_ctrl_model ctl (.core_clk(core_clk), .sda_in(sda_w), .scl(scl), .sda(sda_m));
	gip_target dut (.core_clk(core_clk), .rst(rst), .scl_in(scl), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe(sda_oe), .filt_fast_set(filt_fast_set),
		.filt_fast(filt_fast), .rd_addr(rd_addr), .rd_data(rd_data), .wr_en(wr_en),
		.wr_addr(wr_addr), .wr_data(wr_data), .wr_ro(wr_ro));
	always @(posedge core_clk)
		if (wr_en === 1'b1)
			wlog.push_back({wr_addr, wr_data});
	function automatic gip_word_t rexp(input gip_waddr_t a);
		return {7'h55, a};
	endfunction : rexp
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk16
	task automatic chk1(input logic got, input logic exp);
		total_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk1
	task automatic send(input logic [7:0] v, input logic exp_ack);
		logic a;
		ctl.wbyte(v, a);
		chk1(a, exp_ack);
	endtask : send
	task automatic rword(input logic more);
		ctl.rbyte(1'b1, w[7:0]);
		ctl.rbyte(more, w[15:8]);
	endtask : rword
	task automatic wr_exp(input gip_waddr_t a, input gip_word_t d);
		logic [24:0] e;
		e = (wlog.size() > 0) ? wlog.pop_front() : 25'h0;
		chk16({7'h0, e[24:16]}, {7'h0, a});
		chk16(e[15:0], d);
	endtask : wr_exp
	task automatic t_seq_write();
		ctl.start();
		send(8'h6C, 1'b1);
		send(8'h10, 1'b1);
		send(8'h34, 1'b1);
		send(8'h12, 1'b1);
		send(8'h78, 1'b1);
		send(8'h56, 1'b1);
		ctl.stop();
		wr_exp(9'h010, 16'h1234);
		wr_exp(9'h011, 16'h5678);
	endtask : t_seq_write
	task automatic t_read();
		ctl.start();
		send(8'h6C, 1'b1);
		send(8'h10, 1'b1);
		ctl.start();
		send(8'h6D, 1'b1);
		rword(1'b1);
		chk16(w, rexp(9'h010));
		rword(1'b0);
		chk16(w, rexp(9'h011));
		ctl.stop();
		// low byte only, so the pointer has no cause to move
		repeat (2)
		begin
			ctl.start();
			send(8'h6D, 1'b1);
			ctl.rbyte(1'b0, b);
			ctl.stop();
			chk16({8'h0, b}, 16'h0012);
		end
	endtask : t_read
	task automatic t_upper();
		ctl.start();
		send(8'h6E, 1'b1);
		send(8'h85, 1'b1);
		send(8'hCD, 1'b1);
		send(8'hAB, 1'b1);
		ctl.start();
		send(8'h6F, 1'b1);
		rword(1'b0);
		chk16(w, rexp(9'h186));
		ctl.start();
		send(8'h6E, 1'b1);
		send(8'h10, 1'b1);
		send(8'h22, 1'b1);
		send(8'h33, 1'b1);
		ctl.stop();
		wr_exp(9'h185, 16'hABCD);
		chk16(16'(wlog.size()), 16'h0000);
	endtask : t_upper
	task automatic t_refuse();
		ctl.start();
		send(8'h00, 1'b0);
		ctl.stop();
		ctl.start();
		send(8'hF8, 1'b0);
		ctl.stop();
		ctl.start();
		send(8'h6A, 1'b0);
		send(8'h6C, 1'b0);
		ctl.stop();
		ctl.start();
		send(8'h6C, 1'b1);
		ctl.stop();
	endtask : t_refuse
	task automatic t_edge();
		ctl.start();
		send(8'h6C, 1'b1);
		send(8'hFE, 1'b1);
		for (int i = 1; i <= 6; i++)
			send(8'(8'h11 * i), 1'b1);
		ctl.stop();
		wr_exp(9'h0FF, 16'h4433);
		chk16(16'(wlog.size()), 16'h0000);
	endtask : t_edge
	task automatic t_filter();
		filt_fast_set = 1'b1;
		@(posedge core_clk);
		#1;
		filt_fast_set = 1'b0;
		chk1(filt_fast, 1'b1);
		ctl.start();
		send(8'h6C, 1'b1);
		ctl.start();
		chk1(filt_fast, 1'b1);
		ctl.stop();
		chk1(filt_fast, 1'b0);
	endtask : t_filter
	task automatic conclude();
		if (failures == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : conclude
	initial
	begin
		rst = 1'b1;
		filt_fast_set = 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
		rst = 1'b0;
		ctl.hold();
		chk1(sda_oe, 1'b0);
		t_seq_write();
		t_read();
		t_upper();
		t_refuse();
		t_edge();
		t_filter();
		conclude();
	end
	// a clean run takes about 101k cycles at the top bit rate
	initial
	begin
		repeat (110000) @(posedge core_clk);
		failures++;
		conclude();
	end
endmodule : gip_target_tb_top
